// file: agen_pkg.sv
// Shared constants, types and helpers for the CPU address generator
package agen_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int LEN_W = 3;
    localparam int REG_IDX_W = 5;
    localparam int PAIR_IDX_W = 3;
    localparam int FAR_W = 11;
    localparam int TBL_IDX_W = 5;

    // Branch target constants
    localparam int DISP_SIGN = 7;
    localparam int TBL_FIELD_LSB = 1;
    localparam int TBL_FIELD_MSB = 5;
    localparam logic [4:0] FAR_CALL_PAGE = 5'h01;
    localparam logic [ADDR_W-1:0] CALL_TABLE_BASE = 16'h0040;

    // Operand window constants
    localparam logic [6:0] SADDR_TOP = 7'h7F;
    localparam logic [DATA_W-1:0] SADDR_WRAP = 8'h20;
    localparam logic [ADDR_W-1:0] HSRAM_LO = 16'hFE20;
    localparam logic [ADDR_W-1:0] HSRAM_HI = 16'hFEFF;
    localparam logic [ADDR_W-1:0] SFR_SHORT_LO = 16'hFF00;
    localparam logic [ADDR_W-1:0] SFR_SHORT_HI = 16'hFF1F;
    localparam logic [ADDR_W-1:0] SFR_GAP_LO = 16'hFFD0;
    localparam logic [ADDR_W-1:0] SFR_GAP_HI = 16'hFFDF;
    localparam logic [DATA_W-1:0] SFR_PAGE = 8'hFF;

    // Register codes: X, A, C, B, E, D, L, H are 0..7; AX, BC, DE, HL are 0..3
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [1:0] PAIR_AX = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

    typedef enum logic [2:0] {br_seq, br_rel, br_abs, br_far, br_table, br_acc_pair} agen_br_kind_t;
    typedef enum logic [2:0] {om_none, om_reg8, om_reg16, om_direct, om_saddr, om_saddr16, om_sfr, om_sfr16}
        agen_opnd_mode_t;
    typedef enum logic [2:0] {im_none, im_unsigned_multiply_op, im_unsigned_word_divide_op, im_adjust, im_rotate} agen_impl_t;

    function automatic logic [ADDR_W-1:0] agen_sext(input logic [DATA_W-1:0] d);
        agen_sext = {{(ADDR_W-DATA_W){d[DISP_SIGN]}}, d};
    endfunction

    function automatic logic [REG_IDX_W-1:0] agen_reg_index(input logic [1:0] bank, input logic [2:0] code);
        agen_reg_index = {bank, code};
    endfunction

    function automatic logic [PAIR_IDX_W:0] agen_pair_index(input logic [1:0] bank, input logic [1:0] code);
        agen_pair_index = {bank, code};
    endfunction

endpackage

// file: agen_branch_calc.sv
// Combinational branch target former
`timescale 1ns/100ps
module agen_branch_calc (
    input wire agen_pkg::agen_br_kind_t kind_i,
    input wire logic [agen_pkg::ADDR_W-1:0] pc_i,
    input wire logic [agen_pkg::LEN_W-1:0] len_i,
    input wire logic [agen_pkg::DATA_W-1:0] branch_displacement_i,
    input wire logic [agen_pkg::ADDR_W-1:0] absolute_target_field_i,
    input wire logic [agen_pkg::FAR_W-1:0] far_call_target_field_i,
    input wire logic [agen_pkg::ADDR_W-1:0] accumulator_pair_i,
    output logic [agen_pkg::ADDR_W-1:0] target_o
);
    import agen_pkg::*;

    logic [ADDR_W-1:0] next_seq;

    // Start of the following instruction; 16-bit sums wrap by truncation
    assign next_seq = pc_i + {{(ADDR_W-LEN_W){1'b0}}, len_i};

    always_comb begin
        case (kind_i)
            br_rel: target_o = next_seq + agen_sext(branch_displacement_i);
            br_abs: target_o = absolute_target_field_i;
            br_far: target_o = {FAR_CALL_PAGE, far_call_target_field_i};
            br_acc_pair: target_o = accumulator_pair_i;
            default: target_o = next_seq;
        endcase
    end

endmodule

// file: agen_opnd_calc.sv
// Combinational operand address former
`timescale 1ns/100ps
module agen_opnd_calc (
    input wire agen_pkg::agen_opnd_mode_t mode_i,
    input wire logic [agen_pkg::ADDR_W-1:0] field_i,
    output logic [agen_pkg::ADDR_W-1:0] addr_o,
    output logic hsram_o,
    output logic sfr_o,
    output logic err_o
);
    import agen_pkg::*;

    logic [DATA_W-1:0] low;

    assign low = field_i[DATA_W-1:0];

    always_comb begin
        addr_o = ADDR_ZERO;
        err_o = 1'b0;
        if (mode_i == om_direct) begin
            addr_o = field_i;
        end else if (mode_i == om_saddr || mode_i == om_saddr16) begin
            addr_o = {SADDR_TOP, (low < SADDR_WRAP), low};
            err_o = (mode_i == om_saddr16) && low[0];
        end else if (mode_i == om_sfr || mode_i == om_sfr16) begin
            addr_o = {SFR_PAGE, low};
            err_o = (addr_o >= SFR_GAP_LO && addr_o <= SFR_GAP_HI)
                || ((mode_i == om_sfr16) && low[0]);
        end
    end

    // Area select within the short window and the special register page
    assign hsram_o = (addr_o >= HSRAM_LO) && (addr_o <= HSRAM_HI)
        && (mode_i == om_direct || mode_i == om_saddr || mode_i == om_saddr16);
    assign sfr_o = (addr_o >= SFR_SHORT_LO) && (mode_i != om_none) && (mode_i != om_reg8)
        && (mode_i != om_reg16);

endmodule

// file: agen_top.sv
// CPU address generator: program counter branch targets and operand addresses
`timescale 1ns/100ps
module agen_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Program counter load from the reset and vector logic
    input wire logic pc_load_i,
    input wire logic [agen_pkg::ADDR_W-1:0] pc_load_value_i,
    // Branch request from the decoder
    input wire logic br_valid_i,
    input wire agen_pkg::agen_br_kind_t br_kind_i,
    input wire logic [agen_pkg::LEN_W-1:0] instr_len_i,
    input wire logic [agen_pkg::DATA_W-1:0] opcode_i,
    input wire logic [agen_pkg::DATA_W-1:0] branch_displacement_i,
    input wire logic [agen_pkg::ADDR_W-1:0] absolute_target_field_i,
    input wire logic [agen_pkg::FAR_W-1:0] far_call_target_field_i,
    input wire logic [agen_pkg::ADDR_W-1:0] accumulator_pair_i,
    output logic br_busy_o,
    output logic pc_update_o,
    output logic [agen_pkg::ADDR_W-1:0] program_counter_o,
    // Call table read port
    output logic tbl_rd_o,
    output logic [agen_pkg::ADDR_W-1:0] tbl_addr_o,
    input wire logic [agen_pkg::DATA_W-1:0] tbl_rdata_i,
    input wire logic tbl_rvalid_i,
    // Operand request from the decoder
    input wire logic opnd_valid_i,
    input wire agen_pkg::agen_opnd_mode_t opnd_mode_i,
    input wire logic [agen_pkg::ADDR_W-1:0] opnd_field_i,
    input wire logic [2:0] opnd_reg_code_i,
    input wire logic [1:0] register_pair_operand_i,
    input wire logic bank_select_flag_low_i,
    input wire logic bank_select_flag_high_i,
    input wire agen_pkg::agen_impl_t implied_op_i,
    output logic opnd_done_o,
    output logic [agen_pkg::ADDR_W-1:0] opnd_addr_o,
    output logic opnd_is_reg_o,
    output logic opnd_wide_o,
    output logic [agen_pkg::REG_IDX_W-1:0] opnd_reg_index_o,
    output logic [agen_pkg::PAIR_IDX_W:0] opnd_pair_index_o,
    output logic opnd_hsram_o,
    output logic opnd_sfr_o,
    output logic opnd_err_o,
    // Implied operand selection
    output logic impl_valid_o,
    output logic [agen_pkg::REG_IDX_W-1:0] impl_src_index_o,
    output logic [agen_pkg::REG_IDX_W-1:0] impl_aux_index_o,
    output logic impl_aux_used_o,
    output logic [agen_pkg::PAIR_IDX_W:0] impl_dst_pair_o,
    output logic impl_dst_wide_o
);
    import agen_pkg::*;

    typedef enum logic [1:0] {st_idle, st_tbl_lo, st_tbl_hi} agen_state_t;

    logic rst_sync1;
    logic rst_sync2;
    logic rst_n;
    agen_state_t state;
    logic [DATA_W-1:0] tbl_low;
    logic [ADDR_W-1:0] br_target;
    logic [ADDR_W-1:0] opnd_addr_calc;
    logic opnd_hsram_calc;
    logic opnd_sfr_calc;
    logic opnd_err_calc;
    logic [1:0] bank;
    logic br_take;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    // Asserted at once, released two edges later to avoid metastable release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_sync2 <= rst_sync1;
        end
    end

    assign rst_n = rst_sync2;
    assign bank = {bank_select_flag_high_i, bank_select_flag_low_i};
    assign br_take = br_valid_i && (state == st_idle) && !pc_load_i;

    ////////////////////////////////////////////////////////////////////////////
    // Target formers

    agen_branch_calc u_branch (
        .kind_i(br_kind_i),
        .pc_i(program_counter_o),
        .len_i(instr_len_i),
        .branch_displacement_i(branch_displacement_i),
        .absolute_target_field_i(absolute_target_field_i),
        .far_call_target_field_i(far_call_target_field_i),
        .accumulator_pair_i(accumulator_pair_i),
        .target_o(br_target)
    );

    agen_opnd_calc u_opnd (
        .mode_i(opnd_mode_i),
        .field_i(opnd_field_i),
        .addr_o(opnd_addr_calc),
        .hsram_o(opnd_hsram_calc),
        .sfr_o(opnd_sfr_calc),
        .err_o(opnd_err_calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Table-indirect sequencer

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (br_take && br_kind_i == br_table) begin
                        state <= st_tbl_lo;
                    end
                end
                st_tbl_lo: begin
                    if (tbl_rvalid_i) begin
                        state <= st_tbl_hi;
                    end
                end
                st_tbl_hi: begin
                    if (tbl_rvalid_i) begin
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Entries are little-endian words at 40H + 2 * index, so 40H..7FH
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tbl_rd_o <= 1'b0;
            tbl_addr_o <= ADDR_ZERO;
        end else if (state == st_idle && br_take && br_kind_i == br_table) begin
            tbl_rd_o <= 1'b1;
            tbl_addr_o <= CALL_TABLE_BASE
                + {{(ADDR_W-TBL_IDX_W-1){1'b0}}, opcode_i[TBL_FIELD_MSB:TBL_FIELD_LSB], 1'b0};
        end else if (state == st_tbl_lo && tbl_rvalid_i) begin
            tbl_addr_o <= tbl_addr_o | {{(ADDR_W-1){1'b0}}, 1'b1};
        end else if (state == st_tbl_hi && tbl_rvalid_i) begin
            tbl_rd_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tbl_low <= '0;
        end else if (state == st_tbl_lo && tbl_rvalid_i) begin
            tbl_low <= tbl_rdata_i;
        end
    end

    // Busy covers the table fetch so the decoder holds the next branch
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            br_busy_o <= 1'b0;
        end else if (br_take && br_kind_i == br_table) begin
            br_busy_o <= 1'b1;
        end else if (state == st_tbl_hi && tbl_rvalid_i) begin
            br_busy_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter

    // External load wins over any branch in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            program_counter_o <= ADDR_ZERO;
            pc_update_o <= 1'b0;
        end else begin
            pc_update_o <= 1'b0;
            if (pc_load_i) begin
                program_counter_o <= pc_load_value_i;
                pc_update_o <= 1'b1;
            end else if (state == st_tbl_hi && tbl_rvalid_i) begin
                program_counter_o <= {tbl_rdata_i, tbl_low};
                pc_update_o <= 1'b1;
            end else if (br_take && br_kind_i != br_table) begin
                program_counter_o <= br_target;
                pc_update_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand addressing

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            opnd_done_o <= 1'b0;
            opnd_addr_o <= ADDR_ZERO;
            opnd_hsram_o <= 1'b0;
            opnd_sfr_o <= 1'b0;
            opnd_err_o <= 1'b0;
        end else begin
            opnd_done_o <= opnd_valid_i;
            if (opnd_valid_i) begin
                opnd_addr_o <= opnd_addr_calc;
                opnd_hsram_o <= opnd_hsram_calc;
                opnd_sfr_o <= opnd_sfr_calc;
                opnd_err_o <= opnd_err_calc;
            end
        end
    end

    // Register operands: index is bank flags over the register code
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            opnd_is_reg_o <= 1'b0;
            opnd_wide_o <= 1'b0;
            opnd_reg_index_o <= '0;
            opnd_pair_index_o <= '0;
        end else if (opnd_valid_i) begin
            opnd_is_reg_o <= (opnd_mode_i == om_reg8) || (opnd_mode_i == om_reg16);
            // Word special registers are one 16-bit access, not two bytes
            opnd_wide_o <= (opnd_mode_i == om_reg16) || (opnd_mode_i == om_sfr16)
                || (opnd_mode_i == om_saddr16);
            opnd_reg_index_o <= agen_reg_index(bank, opnd_reg_code_i);
            opnd_pair_index_o <= agen_pair_index(bank, register_pair_operand_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Implied operands

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            impl_valid_o <= 1'b0;
            impl_src_index_o <= '0;
            impl_aux_index_o <= '0;
            impl_aux_used_o <= 1'b0;
            impl_dst_pair_o <= '0;
            impl_dst_wide_o <= 1'b0;
        end else begin
            impl_valid_o <= opnd_valid_i && (implied_op_i != im_none);
            if (opnd_valid_i) begin
                impl_src_index_o <= agen_reg_index(bank, REG_A);
                impl_aux_index_o <= agen_reg_index(bank, REG_X);
                impl_aux_used_o <= 1'b0;
                impl_dst_pair_o <= agen_pair_index(bank, PAIR_AX);
                impl_dst_wide_o <= 1'b0;
                case (implied_op_i)
                    im_unsigned_multiply_op: begin
                        impl_aux_used_o <= 1'b1;
                        impl_dst_wide_o <= 1'b1;
                    end
                    im_unsigned_word_divide_op: begin
                        // Dividend in and quotient out both through the pair
                        impl_dst_wide_o <= 1'b1;
                    end
                    im_adjust, im_rotate: begin
                        impl_dst_wide_o <= 1'b0;
                    end
                    default: begin
                        impl_dst_wide_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// file: agen_top_monitor.sv
// Port-level assertions for the address generator, bound to its top
`timescale 1ns/100ps
module agen_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic pc_load_i,
    input wire logic br_valid_i,
    input wire agen_pkg::agen_br_kind_t br_kind_i,
    input wire logic [2:0] instr_len_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] branch_displacement_i,
    input wire logic [15:0] absolute_target_field_i,
    input wire logic [10:0] far_call_target_field_i,
    input wire logic [15:0] accumulator_pair_i,
    input wire logic br_busy_o,
    input wire logic pc_update_o,
    input wire logic [15:0] program_counter_o,
    input wire logic tbl_rd_o,
    input wire logic [15:0] tbl_addr_o,
    input wire logic opnd_valid_i,
    input wire agen_pkg::agen_opnd_mode_t opnd_mode_i,
    input wire logic [15:0] opnd_field_i,
    input wire logic [2:0] opnd_reg_code_i,
    input wire logic bank_select_flag_low_i,
    input wire logic bank_select_flag_high_i,
    input wire agen_pkg::agen_impl_t implied_op_i,
    input wire logic opnd_done_o,
    input wire logic [15:0] opnd_addr_o,
    input wire logic [4:0] opnd_reg_index_o,
    input wire logic opnd_hsram_o,
    input wire logic opnd_sfr_o,
    input wire logic opnd_err_o,
    input wire logic impl_valid_o,
    input wire logic [4:0] impl_src_index_o,
    input wire logic [4:0] impl_aux_index_o,
    input wire logic [3:0] impl_dst_pair_o
);
    import agen_pkg::*;
    default clocking dcb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Busy also covers a running fetch, so no take is missed
    wire take = br_valid_i && !br_busy_o && !pc_load_i;
    wire [1:0] bank = {bank_select_flag_high_i, bank_select_flag_low_i};
    wire [7:0] fl = opnd_field_i[7:0];
    ////////////////////////////////////////////////////////////////////////
    a_seq_advance: assert property (take && br_kind_i == br_seq |=>
        pc_update_o && program_counter_o == $past(program_counter_o) + $past(instr_len_i)) else $error("bad advance");
    a_rel_target: assert property (take && br_kind_i == br_rel |=> program_counter_o ==
        $past(program_counter_o) + $past(instr_len_i)
        + {{8{$past(branch_displacement_i[7])}}, $past(branch_displacement_i)})
        else $error("bad relative target");
    a_abs_load: assert property (take && br_kind_i == br_abs |=>
        pc_update_o && program_counter_o == $past(absolute_target_field_i)) else $error("bad absolute target");
    a_far_window: assert property (take && br_kind_i == br_far |=>
        program_counter_o == {5'h01, $past(far_call_target_field_i)}) else $error("bad far call target");
    a_acc_jump: assert property (take && br_kind_i == br_acc_pair |=>
        program_counter_o == $past(accumulator_pair_i)) else $error("bad register jump");
    a_tbl_entry: assert property (take && br_kind_i == br_table |=>
        tbl_rd_o && br_busy_o && tbl_addr_o == {9'h000, 1'b1, $past(opcode_i[5:1]), 1'b0}) else $error("bad table entry");
    a_tbl_window: assert property (tbl_rd_o |-> tbl_addr_o >= 16'h0040 && tbl_addr_o <= 16'h007F)
        else $error("table read outside table");
    a_direct_addr: assert property (opnd_valid_i && opnd_mode_i == om_direct |=>
        opnd_done_o && opnd_addr_o == $past(opnd_field_i)) else $error("bad direct address");
    a_saddr_addr: assert property (opnd_valid_i && opnd_mode_i == om_saddr |=>
        opnd_addr_o == {7'h7F, $past(fl) < 8'h20, $past(fl)}) else $error("bad short direct address");
    a_saddr_area: assert property (opnd_valid_i && opnd_mode_i == om_saddr |=>
        opnd_hsram_o != opnd_sfr_o && opnd_sfr_o == ($past(fl) < 8'h20)) else $error("bad short direct area");
    a_sfr_addr: assert property (opnd_valid_i && opnd_mode_i == om_sfr |=>
        opnd_addr_o == {8'hFF, $past(fl)} && opnd_err_o == ($past(fl[7:4]) == 4'hD)) else $error("bad sfr address");
    a_sfr16_odd: assert property (opnd_valid_i && opnd_mode_i == om_sfr16 && fl[0] |=> opnd_err_o)
        else $error("odd word sfr accepted");
    a_reg_index: assert property (opnd_valid_i && opnd_mode_i == om_reg8 |=>
        opnd_reg_index_o == {$past(bank), $past(opnd_reg_code_i)}) else $error("bad register index");
    a_unsigned_multiply_op_impl: assert property (opnd_valid_i && implied_op_i == im_unsigned_multiply_op |=> impl_valid_o &&
        impl_src_index_o == {$past(bank), REG_A} && impl_aux_index_o == {$past(bank), REG_X} &&
        impl_dst_pair_o == {$past(bank), PAIR_AX}) else $error("bad multiply operands");
    c_table_done: cover property (tbl_rd_o ##1 !tbl_rd_o && pc_update_o);
    c_saddr_low: cover property (opnd_valid_i && opnd_mode_i == om_saddr && fl < 8'h20);
    c_rel_back: cover property (take && br_kind_i == br_rel && branch_displacement_i[7]);
endmodule
bind agen_top agen_monitor i_monitor (.*);

// file: agen_top_bench.sv
// Self-checking bench for the address generator
`timescale 1ns/100ps
`define chk(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module agen_top_bench;
    import agen_pkg::*;
    logic ref_clk_i, rst_n_i, pc_load_i, br_valid_i, br_busy_o, pc_update_o, tbl_rd_o, tbl_rvalid_i;
    logic opnd_valid_i, bank_select_flag_low_i, bank_select_flag_high_i, opnd_done_o, opnd_is_reg_o, opnd_wide_o;
    logic opnd_hsram_o, opnd_sfr_o, opnd_err_o, impl_valid_o, impl_aux_used_o, impl_dst_wide_o;
    logic [2:0] instr_len_i, opnd_reg_code_i;
    logic [1:0] register_pair_operand_i;
    logic [7:0] opcode_i, branch_displacement_i, tbl_rdata_i;
    logic [10:0] far_call_target_field_i;
    logic [15:0] pc_load_value_i, absolute_target_field_i, accumulator_pair_i, program_counter_o, tbl_addr_o;
    logic [15:0] opnd_field_i, opnd_addr_o;
    logic [4:0] opnd_reg_index_o, impl_src_index_o, impl_aux_index_o;
    logic [3:0] opnd_pair_index_o, impl_dst_pair_o;
    agen_br_kind_t br_kind_i;
    agen_opnd_mode_t opnd_mode_i;
    agen_impl_t implied_op_i;
    agen_br_kind_t kinds[5] = '{br_seq, br_rel, br_abs, br_far, br_acc_pair};
    int mismatches, samples_checked, exp_pc, ea, b, bank;
    // Field corners around the window and gap edges
    int sweep[9] = '{'h00, 'h01, 'h1F, 'h20, 'hCF, 'hD0, 'hDF, 'hE0, 'hFF};
    bit pend;
    logic [31:0] seed = 32'h3fb5;
    logic [31:0] v;
    agen_top i_dut (.*);
    initial begin
        ref_clk_i = 0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Issues back to back; each edge checks the previous request
    task automatic br_issue(input agen_br_kind_t k, input logic [2:0] l, input logic [7:0] d, input logic [15:0] a);
        @(negedge ref_clk_i);
        if (pend) begin
            `chk("program_counter", 16'(exp_pc), program_counter_o)
            `chk("pc_update", 1'b1, pc_update_o)
        end
        br_valid_i = 1;
        {br_kind_i, instr_len_i, branch_displacement_i} = {k, l, d};
        {absolute_target_field_i, far_call_target_field_i, accumulator_pair_i} = {a, a[10:0], ~a};
        case (k)
            br_seq: exp_pc = (exp_pc + l) & 'hFFFF;
            br_rel: exp_pc = (exp_pc + l + int'($signed(d))) & 'hFFFF;
            br_far: exp_pc = 'h800 + a[10:0];
            br_acc_pair: exp_pc = 16'(~a);
            default: exp_pc = a;
        endcase
        pend = (k != br_table);
    endtask
    task automatic tbl_call(input logic [7:0] opc, input logic [15:0] dst);
        br_issue(br_table, 3'h1, 8'h00, 16'h1234);
        opcode_i = opc;
        @(negedge ref_clk_i);
        br_kind_i = br_abs;
        `chk("tbl_addr", 16'('h40 + 2 * opc[5:1]), tbl_addr_o)
        `chk("tbl_rd", 1'b1, tbl_rd_o)
        // Far side stalls two cycles; abs requests meanwhile must be ignored
        repeat (2) @(negedge ref_clk_i);
        tbl_rdata_i = dst[7:0];
        tbl_rvalid_i = 1;
        @(negedge ref_clk_i);
        tbl_rvalid_i = 0;
        tbl_rdata_i = ~dst[7:0];
        `chk("tbl_addr_hi", 16'('h41 + 2 * opc[5:1]), tbl_addr_o)
        @(negedge ref_clk_i);
        tbl_rdata_i = dst[15:8];
        tbl_rvalid_i = 1;
        @(negedge ref_clk_i);
        tbl_rvalid_i = 0;
        br_valid_i = 0;
        `chk("tbl_target", dst, program_counter_o)
        `chk("tbl_busy", 1'b0, br_busy_o)
        `chk("tbl_rd_end", 1'b0, tbl_rd_o)
        exp_pc = dst;
    endtask
    task automatic op(input agen_opnd_mode_t m, input logic [15:0] f, input logic [6:0] r, input agen_impl_t im);
        @(negedge ref_clk_i);
        {opnd_valid_i, opnd_mode_i, opnd_field_i, implied_op_i} = {1'b1, m, f, im};
        {bank_select_flag_high_i, bank_select_flag_low_i, register_pair_operand_i, opnd_reg_code_i} = r;
        @(negedge ref_clk_i);
        opnd_valid_i = 0;
        b = f[7:0];
        bank = r[6:5];
        case (m)
            om_direct: ea = f;
            om_saddr, om_saddr16: ea = 'hFE00 + b + (b < 'h20 ? 'h100 : 0);
            om_sfr, om_sfr16: ea = 'hFF00 + b;
            default: ea = 0;
        endcase
        `chk("done", 1'b1, opnd_done_o)
        `chk("is_reg", 1'(m inside {om_reg8, om_reg16}), opnd_is_reg_o)
        `chk("wide", 1'(m inside {om_reg16, om_sfr16, om_saddr16}), opnd_wide_o)
        `chk("impl_valid", 1'(im != im_none), impl_valid_o)
        `chk("addr", 16'(ea), opnd_addr_o)
        `chk("err", 1'(m >= om_sfr && b[7:4] == 'hD || m inside {om_sfr16, om_saddr16} && b[0]), opnd_err_o)
        `chk("hsram", 1'(m inside {om_direct, om_saddr, om_saddr16} && ea >= 'hFE20 && ea <= 'hFEFF), opnd_hsram_o)
        `chk("sfr", 1'(m >= om_direct && ea >= 'hFF00), opnd_sfr_o)
        if (m == om_reg8) `chk("reg_index", 5'(bank * 8 + r[2:0]), opnd_reg_index_o)
        if (m == om_reg16) `chk("pair_index", 4'(bank * 4 + r[4:3]), opnd_pair_index_o)
        if (im != im_none) begin
            `chk("impl_src", 5'(bank * 8 + 1), impl_src_index_o)
            `chk("impl_wide", 1'(im inside {im_unsigned_multiply_op, im_unsigned_word_divide_op}), impl_dst_wide_o)
            `chk("impl_aux", 1'(im == im_unsigned_multiply_op), impl_aux_used_o)
            `chk("impl_aux_index", 5'(bank * 8), impl_aux_index_o)
        end
        if (im inside {im_unsigned_multiply_op, im_unsigned_word_divide_op}) `chk("impl_pair", 4'(bank * 4), impl_dst_pair_o)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_i = 0;
        {pc_load_i, br_valid_i, tbl_rvalid_i, opnd_valid_i, bank_select_flag_low_i, bank_select_flag_high_i} = '0;
        {instr_len_i, opnd_reg_code_i, register_pair_operand_i, opcode_i, branch_displacement_i, tbl_rdata_i} = '0;
        {far_call_target_field_i, pc_load_value_i, absolute_target_field_i, accumulator_pair_i, opnd_field_i} = '0;
        {br_kind_i, opnd_mode_i, implied_op_i} = {br_seq, om_none, im_none};
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        {pc_load_i, pc_load_value_i, br_valid_i, br_kind_i} = {1'b1, 16'hFFFE, 1'b1, br_abs};
        @(negedge ref_clk_i);
        {pc_load_i, br_valid_i} = 2'b00;
        `chk("pc_load", 16'hFFFE, program_counter_o)
        exp_pc = 'hFFFE;
        // Wrap past the top, back across zero, then random mix
        br_issue(br_rel, 3'h2, 8'h7F, 16'h0000);
        br_issue(br_rel, 3'h2, 8'h80, 16'h0000);
        br_issue(br_rel, 3'h4, 8'hF0, 16'h0000);
        repeat (60) begin
            v = xs();
            br_issue(kinds[v % 5], 3'(1 + v[9:8]), v[17:10], v[31:16]);
        end
        foreach (kinds[i]) tbl_call(8'(i * 8'h3E), 16'(xs()));
        for (int i = 0; i < 9; i++) begin
            for (int m = 3; m < 8; m++) op(agen_opnd_mode_t'(m), {8'(xs() >> 24), 8'(sweep[i])}, 7'(xs()), im_none);
        end
        repeat (80) begin
            v = xs();
            op(agen_opnd_mode_t'(v[2:0]), v[23:8], v[30:24], im_none);
        end
        for (int i = 0; i < 20; i++) op(om_none, 16'h0000, 7'(xs()), agen_impl_t'(i % 5));
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        report_and_stop();
    end
endmodule
